// ### rtl/ts_filter_regs.vh
// Constants of the UDP port window transport stream input filter
// Summary of operation
// - Pass a stream only if its UDP port lies in a 2048-wide window at the offset.
// - Port offset reads 57000 after reset until software writes another value.
// - Offset writes leave the read data unchanged; a query returns the offset.
// - Null packet discard exists, is on after reset, drops nulls at the third header byte.
// - When set, drop packets whose transport error bit is 1; otherwise pass unchanged.
// - Each window port has an 8192-entry PID store, readable back by software.
`ifndef TS_FILTER_REGS_VH
`define TS_FILTER_REGS_VH
`define ADDR_OFFSET      8'h00
`define ADDR_CONTROL     8'h04
`define ADDR_STATUS      8'h08
`define ADDR_PID_ADDR    8'h0C
`define ADDR_PID_DATA    8'h10
`define OFFSET_RESET     16'hDEA8
`define WINDOW_SIZE      17'h00800
`define CTRL_NULL_BIT    0
`define CTRL_TEI_BIT     1
`define CTRL_RESET       2'h1
`define NULL_PID         13'h1FFF
`define SYNC_BYTE        8'h47
`define TEI_BIT          7
`define PKT_LEN          8'hBC
`define HDR_B1_POS       8'h01
`define TAIL_LEN         2'h2
`define PID_ENTRY_W      1
`endif

// ### rtl/pkt_header_check.v
// Header decoder deciding keep or drop for one transport packet
`timescale 1ns/1ps
`include "ts_filter_regs.vh"
module pkt_header_check
(
    input  wire [7:0]  hdr_b1,
    input  wire [7:0]  hdr_b2,
    input  wire [15:0] port,
    input  wire [15:0] offset,
    input  wire        null_drop,
    input  wire        tei_drop,
    output wire [12:0] pid,
    output wire        in_window,
    output wire        keep
);
    wire [16:0] rel;
    wire        is_null;
    wire        is_err;
    assign rel       = {1'b0, port} - {1'b0, offset};
    assign in_window = (port >= offset) && (rel < `WINDOW_SIZE);
    assign pid       = {hdr_b1[4:0], hdr_b2};
    assign is_null   = (pid == `NULL_PID);
    assign is_err    = hdr_b1[`TEI_BIT];
    assign keep      = in_window && !(null_drop && is_null)
                       && !(tei_drop && is_err);
endmodule // pkt_header_check

// ### rtl/ts_input_filter.v
// UDP port window transport stream input filter with AHB-Lite registers
`timescale 1ns/1ps
`include "ts_filter_regs.vh"
module ts_input_filter
#(
    parameter PORT_BITS = 11,
    parameter PID_BITS  = 13
)
(
    input  wire        clock,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [7:0]  in_data,
    input  wire        in_valid,
    input  wire        in_sop,
    input  wire [15:0] in_port,
    output reg  [7:0]  out_data,
    output reg         out_valid,
    output reg         out_sop,
    output reg  [PORT_BITS-1:0] out_port_idx,
    output reg  [PID_BITS-1:0]  out_pid
);
    localparam DEPTH = (1 << (PORT_BITS + PID_BITS));
    localparam S_IDLE = 2'b00;
    localparam S_HDR  = 2'b01;
    localparam S_BODY = 2'b10;

    reg [15:0] offset_q;
    reg [1:0]  ctrl_q;
    reg [31:0] pass_cnt_q;
    reg [PORT_BITS+PID_BITS-1:0] pid_addr_q;
    reg        pid_mem [0:DEPTH-1];
    reg        pid_rd_q;

    reg        dph_q;
    reg        dwr_q;
    reg [7:0]  dadr_q;

    reg [1:0]  st_q;
    reg [7:0]  b0_q;
    reg [7:0]  b1_q;
    reg [7:0]  p1_q;
    reg [7:0]  p2_q;
    reg [1:0]  tail_q;
    reg [7:0]  cnt_q;
    reg [15:0] port_q;
    reg        keep_q;

    // Next values of the stream registers
    reg [1:0]  st_d;
    reg [7:0]  b0_d;
    reg [7:0]  b1_d;
    reg [7:0]  p1_d;
    reg [7:0]  p2_d;
    reg [1:0]  tail_d;
    reg [7:0]  cnt_d;
    reg [15:0] port_d;
    reg        keep_d;
    reg [31:0] pass_cnt_d;
    reg [7:0]  out_data_d;
    reg        out_valid_d;
    reg        out_sop_d;
    reg [PORT_BITS-1:0] out_port_idx_d;
    reg [PID_BITS-1:0]  out_pid_d;

    // Stream decodes
    wire        sop_ok;
    wire        last_byte;
    wire        flushing;

    wire [12:0] chk_pid;
    wire        chk_win;
    wire        chk_keep;
    wire [15:0] port_rel;

    assign port_rel  = in_port - offset_q;
    assign sop_ok    = in_sop && (in_data == `SYNC_BYTE);
    assign last_byte = (cnt_q == `PKT_LEN - 8'h01);
    assign flushing  = (tail_q != 2'b00);

    pkt_header_check u_chk
    (
        .hdr_b1    (b1_q),
        .hdr_b2    (in_data),
        .port      (port_q),
        .offset    (offset_q),
        .null_drop (ctrl_q[`CTRL_NULL_BIT]),
        .tei_drop  (ctrl_q[`CTRL_TEI_BIT]),
        .pid       (chk_pid),
        .in_window (chk_win),
        .keep      (chk_keep)
    );

    // Bus address phase capture
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            dph_q     <= 1'b0;
            dwr_q     <= 1'b0;
            dadr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
            begin
                dph_q  <= hsel && htrans[1];
                dwr_q  <= hwrite;
                dadr_q <= haddr[7:0];
            end
        end
    end

    // Register writes and read data
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            offset_q   <= `OFFSET_RESET;
            ctrl_q     <= `CTRL_RESET;
            pid_addr_q <= {(PORT_BITS+PID_BITS){1'b0}};
            hrdata     <= 32'h00000000;
        end
        else
        begin
            if (dph_q && dwr_q)
            begin
                case (dadr_q)
                    `ADDR_OFFSET:   offset_q   <= hwdata[15:0];
                    `ADDR_CONTROL:  ctrl_q     <= hwdata[1:0];
                    `ADDR_PID_ADDR: pid_addr_q <= hwdata[PORT_BITS+PID_BITS-1:0];
                    default:        ;
                endcase
            end
            if (hready && hsel && htrans[1] && !hwrite)
            begin
                // Read answers with the value held during the address phase
                case (haddr[7:0])
                    `ADDR_OFFSET:   hrdata <= {16'h0000, offset_q};
                    `ADDR_CONTROL:  hrdata <= {30'h00000000, ctrl_q};
                    `ADDR_STATUS:   hrdata <= pass_cnt_q;
                    `ADDR_PID_ADDR: hrdata <= {{(32-PORT_BITS-PID_BITS){1'b0}}, pid_addr_q};
                    `ADDR_PID_DATA: hrdata <= {31'h00000000, pid_rd_q};
                    default:        hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // PID store: one entry per window port and PID, written and read by software
    always @(posedge clock)
    begin
        if (dph_q && dwr_q && (dadr_q == `ADDR_PID_DATA))
            pid_mem[pid_addr_q] <= hwdata[0];
        pid_rd_q <= pid_mem[pid_addr_q];
    end

    // Packet stream next state: the first header bytes are held until the
    // keep decision at the third byte; after it every byte leaves two input
    // bytes late, so the last two bytes are flushed once the packet has ended
    always @*
    begin
        st_d           = st_q;
        b0_d           = b0_q;
        b1_d           = b1_q;
        p1_d           = p1_q;
        p2_d           = p2_q;
        tail_d         = tail_q;
        cnt_d          = cnt_q;
        port_d         = port_q;
        keep_d         = keep_q;
        pass_cnt_d     = pass_cnt_q;
        out_data_d     = out_data;
        out_valid_d    = 1'b0;
        out_sop_d      = 1'b0;
        out_port_idx_d = out_port_idx;
        out_pid_d      = out_pid;

        if (flushing)
        begin
            // A following header needs three bytes before it emits anything,
            // so the flush is over before the delay line is loaded again
            out_data_d  = p1_q;
            out_valid_d = 1'b1;
            p1_d        = p2_q;
            tail_d      = tail_q - 2'b01;
        end

        if (in_valid)
        begin
            if (sop_ok)
            begin
                // The port stands on the pins with the first byte
                st_d           = S_HDR;
                b0_d           = in_data;
                cnt_d          = `HDR_B1_POS;
                port_d         = in_port;
                out_port_idx_d = port_rel[PORT_BITS-1:0];
            end
            else
            begin
                case (st_q)
                    S_HDR:
                    begin
                        cnt_d = cnt_q + 8'h01;
                        if (cnt_q == `HDR_B1_POS)
                            b1_d = in_data;
                        else
                        begin
                            keep_d    = chk_keep;
                            out_pid_d = chk_pid;
                            p1_d      = b1_q;
                            p2_d      = in_data;
                            st_d      = S_BODY;
                            if (chk_keep)
                            begin
                                pass_cnt_d  = pass_cnt_q + 32'h00000001;
                                out_data_d  = b0_q;
                                out_valid_d = 1'b1;
                                out_sop_d   = 1'b1;
                            end
                        end
                    end
                    S_BODY:
                    begin
                        // Two-byte delay line behind the header
                        cnt_d = cnt_q + 8'h01;
                        p1_d  = p2_q;
                        p2_d  = in_data;
                        if (keep_q)
                        begin
                            out_data_d  = p1_q;
                            out_valid_d = 1'b1;
                        end
                        if (last_byte)
                        begin
                            st_d = S_IDLE;
                            if (keep_q)
                                tail_d = `TAIL_LEN;
                        end
                    end
                    default: st_d = S_IDLE;
                endcase
            end
        end
    end

    // Packet stream registers
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            st_q         <= S_IDLE;
            b0_q         <= 8'h00;
            b1_q         <= 8'h00;
            p1_q         <= 8'h00;
            p2_q         <= 8'h00;
            tail_q       <= 2'b00;
            cnt_q        <= 8'h00;
            port_q       <= 16'h0000;
            keep_q       <= 1'b0;
            pass_cnt_q   <= 32'h00000000;
            out_data     <= 8'h00;
            out_valid    <= 1'b0;
            out_sop      <= 1'b0;
            out_port_idx <= {PORT_BITS{1'b0}};
            out_pid      <= {PID_BITS{1'b0}};
        end
        else
        begin
            st_q         <= st_d;
            b0_q         <= b0_d;
            b1_q         <= b1_d;
            p1_q         <= p1_d;
            p2_q         <= p2_d;
            tail_q       <= tail_d;
            cnt_q        <= cnt_d;
            port_q       <= port_d;
            keep_q       <= keep_d;
            pass_cnt_q   <= pass_cnt_d;
            out_data     <= out_data_d;
            out_valid    <= out_valid_d;
            out_sop      <= out_sop_d;
            out_port_idx <= out_port_idx_d;
            out_pid      <= out_pid_d;
        end
    end
endmodule // ts_input_filter

// ### tb/ts_input_filter_chk.sv
// Port assertions for the transport stream input filter
`timescale 1ns/1ps
module ts_input_filter_chk
(
    input wire        clock,
    input wire        rst_b,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        in_valid,
    input wire [7:0]  out_data,
    input wire        out_valid,
    input wire        out_sop
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence rd_s;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence gap_s;
        !out_sop [*8];
    endsequence
    chk_ready_high: assert property (hreadyout) else $error("hreadyout dropped");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_read_answer: assert property (rd_s |=> hreadyout && !hresp)
        else $error("read not answered");
    chk_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed without read");
    chk_sop_sync: assert property (out_sop |-> out_valid && out_data == 8'h47)
        else $error("packet start without sync byte");
    chk_sop_next: assert property (out_sop |=> out_valid)
        else $error("packet start not followed by byte");
    chk_sop_gap: assert property (out_sop |=> gap_s)
        else $error("packet starts too close");
    chk_out_cause: assert property (out_valid |-> $past(in_valid) || $past(in_valid, 2) || $past(in_valid, 3))
        else $error("output byte without input byte");
endmodule // ts_input_filter_chk
bind ts_input_filter ts_input_filter_chk chk (.clock(clock), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .in_valid(in_valid), .out_data(out_data), .out_valid(out_valid), .out_sop(out_sop));

// ### tb/ts_source.sv
// Network side model sending UDP carried transport packets
`timescale 1ns/1ps
module ts_source
(
    input  wire        clock,
    output reg  [7:0]  in_data = 8'h00,
    output reg         in_valid = 1'h0,
    output reg         in_sop = 1'h0,
    output reg  [15:0] in_port = 16'h0000
);
    task send(input [15:0] port, input [12:0] pid, input tei);
        integer i;
        begin
            for (i = 0; i < 188; i = i + 1)
            begin
                @(posedge clock);
                in_valid <= 1'h1;
                in_sop   <= (i == 0);
                in_port  <= port;
                in_data  <= (i == 0) ? 8'h47 : (i == 1) ? {tei, 2'h0, pid[12:8]} : (i == 2) ? pid[7:0] : i[7:0];
            end
            @(posedge clock);
            in_valid <= 1'h0;
            in_sop   <= 1'h0;
            in_data  <= ~in_data;
            in_port  <= ~port;
        end
    endtask
endmodule // ts_source

// ### tb/ts_input_filter_tb.sv
// Self-checking bench for the transport stream input filter
`timescale 1ns/1ps
module ts_input_filter_tb;
    reg         clock = 1'h0;
    reg         rst_b = 1'h0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'h0;
    reg  [31:0] hwdata = 32'h0;
    reg  [31:0] rd;
    reg  [10:0] last_idx = 11'h0;
    integer     err_count = 0;
    integer     num_checks = 0;
    integer     kcnt = 0;
    integer     kexp = 0;
    integer     nbytes = 0;
    integer     bad_bytes = 0;
    integer     opos = 0;
    reg  [12:0] exp_pid = 13'h0;
    reg         exp_tei = 1'h0;
    reg  [12:0] last_pid = 13'h0;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire [7:0]  in_data;
    wire        in_valid;
    wire        in_sop;
    wire [15:0] in_port;
    wire [7:0]  out_data;
    wire        out_valid;
    wire        out_sop;
    wire [12:0] out_pid;
    wire [10:0] out_port_idx;
    always #2.5 clock = ~clock;
    ts_source src (.clock(clock), .in_data(in_data), .in_valid(in_valid), .in_sop(in_sop), .in_port(in_port));
    ts_input_filter dut (.clock(clock), .rst_b(rst_b), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .in_data(in_data), .in_valid(in_valid), .in_sop(in_sop),
        .in_port(in_port), .out_data(out_data), .out_valid(out_valid), .out_sop(out_sop),
        .out_port_idx(out_port_idx), .out_pid(out_pid));
    always @(posedge clock)
        if (out_sop)
        begin
            kcnt     <= kcnt + 1;
            last_idx <= out_port_idx;
            last_pid <= out_pid;
        end
    function [7:0] exp_byte(input integer k);
        begin
            exp_byte = (k == 0) ? 8'h47 : (k == 1) ? {exp_tei, 2'h0, exp_pid[12:8]} : (k == 2) ? exp_pid[7:0] : k[7:0];
        end
    endfunction
    always @(posedge clock)
        if (out_valid)
        begin
            nbytes <= nbytes + 1;
            opos   <= out_sop ? 1 : opos + 1;
            if (out_data !== exp_byte(out_sop ? 0 : opos))
                bad_bytes <= bad_bytes + 1;
        end
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task ahb(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock);
            htrans <= 2'h2;
            haddr  <= {24'h0, a};
            hwrite <= wr;
            @(posedge clock);
            while (hreadyout !== 1'h1) @(posedge clock);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clock);
            while (hreadyout !== 1'h1) @(posedge clock);
            rd = hrdata;
        end
    endtask
    task pkt(input [15:0] port, input [12:0] pid, input tei, input keep, input [10:0] idx);
        integer k0;
        integer n0;
        integer e0;
        begin
            k0 = kcnt;
            n0 = nbytes;
            e0 = bad_bytes;
            exp_pid = pid;
            exp_tei = tei;
            src.send(port, pid, tei);
            repeat (8) @(posedge clock);
            kexp = kexp + keep;
            chk("kept", k0 + keep, kcnt);
            chk("bytes", n0 + 188 * keep, nbytes);
            chk("bad bytes", e0, bad_bytes);
            if (keep)
            begin
                chk("index", {21'h0, idx}, {21'h0, last_idx});
                chk("pid", {19'h0, pid}, {19'h0, last_pid});
            end
        end
    endtask
    task t_reset;
        begin
            ahb(1'h0, 8'h00, 32'h0);
            chk("offset", 32'h0000DEA8, rd);
            ahb(1'h0, 8'h04, 32'h0);
            chk("control", 32'h1, rd);
            ahb(1'h0, 8'h20, 32'h0);
            chk("unmapped", 32'h0, rd);
        end
    endtask
    task t_window;
        begin
            pkt(16'hDEA8, 13'h0100, 1'h0, 1'h1, 11'h000);
            pkt(16'hE6A7, 13'h0100, 1'h0, 1'h1, 11'h7FF);
            pkt(16'hE6A8, 13'h0100, 1'h0, 1'h0, 11'h000);
            pkt(16'hDEA7, 13'h0100, 1'h0, 1'h0, 11'h000);
        end
    endtask
    task t_offset;
        begin
            ahb(1'h1, 8'h00, 32'h03E8);
            ahb(1'h0, 8'h00, 32'h0);
            chk("offset", 32'h03E8, rd);
            ahb(1'h1, 8'h0C, 32'h0);
            ahb(1'h1, 8'h10, 32'h1);
            ahb(1'h1, 8'h0C, 32'hA100);
            ahb(1'h1, 8'h10, 32'h0);
            ahb(1'h1, 8'h0C, 32'h0);
            ahb(1'h0, 8'h10, 32'h0);
            chk("pid entry", 32'h1, rd);
            ahb(1'h1, 8'h0C, 32'hA100);
            ahb(1'h0, 8'h10, 32'h0);
            chk("pid entry", 32'h0, rd);
            pkt(16'h03EF, 13'h0100, 1'h0, 1'h1, 11'h007);
            pkt(16'hDEA8, 13'h0100, 1'h0, 1'h0, 11'h000);
        end
    endtask
    task t_drop;
        begin
            pkt(16'h03E8, 13'h1FFF, 1'h0, 1'h0, 11'h000);
            pkt(16'h03E8, 13'h0100, 1'h1, 1'h1, 11'h000);
            ahb(1'h1, 8'h04, 32'h2);
            pkt(16'h03E8, 13'h1FFF, 1'h0, 1'h1, 11'h000);
            pkt(16'h03E8, 13'h0100, 1'h1, 1'h0, 11'h000);
            pkt(16'h03E9, 13'h0100, 1'h0, 1'h1, 11'h001);
            ahb(1'h1, 8'h04, 32'h1);
            ahb(1'h0, 8'h08, 32'h0);
            chk("passed", kexp, rd);
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        rst_b <= 1'h1;
        t_reset;
        t_window;
        t_offset;
        t_drop;
        print_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count = err_count + 1;
        print_verdict;
    end
endmodule // ts_input_filter_tb
